// *** mmcs_consts.vh ***
// Constants for the memory-map and chip-select decoder.
`ifndef MMCS_CONSTS_VH
`define MMCS_CONSTS_VH
// Register byte addresses (index times four).
`define MMCS_OFF_P4CTL 8'h92
`define MMCS_OFF_MEMCTL 8'hC6
`define MMCS_ADDR_P4CTL 10'h248
`define MMCS_ADDR_MEMCTL 10'h318
`define MMCS_ADDR_ADDRESS_CONTROL 10'h400
`define MMCS_ADDR_STACK 10'h404
`define MMCS_ADDR_STAT 10'h408
// Reset values.
`define MMCS_RST_P4CTL 8'h3F
`define MMCS_RST_MEMCTL 8'h00
`define MMCS_RST_ADDRESS_CONTROL 8'h00
// Field positions.
`define MMCS_MEMCTL_MAPHI 7
`define MMCS_MEMCTL_MAPLO 6
`define MMCS_MEMCTL_CAN 5
`define MMCS_ADDRESS_CONTROL_WSTK 2
`define MMCS_ADDRESS_CONTROL_DEMUX 0
// Window bases.
`define MMCS_SRAM_HI_BASE 11'h00F
`define MMCS_SRAM_LO_BASE 11'h000
`define MMCS_SRAM_UP_BASE 11'h400
`define MMCS_CAN_LO_BASE 14'h0077
`define MMCS_CAN_UP_BASE 14'h2008
`define MMCS_STACK_TOP 2'h0
// Internal access length in cycles.
`define MMCS_INT_CYCLES 2'h2
`endif

// *** mmcs_ce_decode.v ***
// Program chip-enable block decoder for one chip enable.
`timescale 1ns/1ps
module mmcs_ce_decode #(
  parameter [1:0] IDX = 2'h0
) (
  input wire [21:0] addr,
  input wire [2:0] upper_code,
  input wire [2:0] ce_code,
  output reg hit
);
  // Number of chip enables that the pin code turns on.
  reg [2:0] ce_count;
  // Block index picked by the upper-address code.
  reg [2:0] blk;
  // Address bits above the block decode, which must be zero.
  reg high_zero;
  // Decode the block index and enable.
  always @* begin
    case (ce_code)
      3'h4: ce_count = 3'h1;
      3'h5: ce_count = 3'h2;
      3'h6: ce_count = 3'h3;
      3'h7: ce_count = 3'h4;
      default: ce_count = 3'h0;
    endcase
    case (upper_code)
      3'h4: begin
        blk = {1'b0, addr[18:17]};
        high_zero = (addr[21:19] == 3'h0);
      end
      3'h5: begin
        blk = {1'b0, addr[19:18]};
        high_zero = (addr[21:20] == 2'h0);
      end
      3'h6: begin
        blk = {1'b0, addr[20:19]};
        high_zero = ~addr[21];
      end
      3'h7: begin
        blk = {1'b0, addr[21:20]};
        high_zero = 1'b1;
      end
      default: begin
        blk = {1'b0, addr[16:15]};
        high_zero = (addr[21:17] == 5'h00);
      end
    endcase
    hit = high_zero && (blk[1:0] == IDX) && ({1'b0, IDX} < ce_count);
  end
endmodule

// *** mmcs_top.v ***
// Memory-map and chip-select decoder with its Avalon-MM register slave.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "mmcs_consts.vh"
module mmcs_top (
  input wire clk_sys,
  input wire srst,
  // Avalon-MM slave.
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Core access request, same clock.
  input wire acc_req,
  input wire acc_code,
  input wire acc_stack,
  input wire acc_wr,
  input wire [22:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire [7:0] stack_ptr,
  output reg acc_done,
  output reg acc_internal,
  output reg acc_can,
  output reg [11:0] sram_addr,
  output reg [8:0] can_addr,
  // External bus pins.
  output reg [7:0] port4_out,
  output reg [7:0] port4_oe,
  output reg [3:0] port5_hi_out,
  output reg [7:0] port2_out,
  output reg [7:0] port1_out,
  output reg port1_oe,
  output reg [7:0] port0_out,
  output reg port0_oe,
  output reg ale,
  output reg write_strobe_n,
  output reg read_strobe_n,
  output reg program_read_strobe_n
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  reg [7:0] port4_function_control_r; // Port 4 pin functions.
  reg [7:0] memory_control_r; // Map, CAN area and combined selects.
  reg [7:0] address_control_r; // Wide stack and bus mode.
  reg [1:0] stack_ptr_ext_r; // Upper stack pointer bits.
  reg [2:0] access_count_r; // Counts completed accesses.
  reg wr_done_r; // Blocks a second request, read or write, in the ack cycle.
  wire internal_map_sel_hi = memory_control_r[`MMCS_MEMCTL_MAPHI];
  wire internal_map_sel_lo = memory_control_r[`MMCS_MEMCTL_MAPLO];
  wire can_area_sel = memory_control_r[`MMCS_MEMCTL_CAN];
  wire [3:0] combined_chip_sel = memory_control_r[3:0];
  wire shared_mode = internal_map_sel_hi & internal_map_sel_lo;
  // Wide stack is not available when the SRAM is shared.
  wire wide_stack_en = address_control_r[`MMCS_ADDRESS_CONTROL_WSTK] & ~shared_mode;
  wire demux_mode = address_control_r[`MMCS_ADDRESS_CONTROL_DEMUX];
  wire [2:0] upper_code = port4_function_control_r[5:3];
  wire [2:0] ce_code = port4_function_control_r[2:0];
  ////////////////////////////////////////////////////////////////////////////
  // Register bus: one wait cycle, then the answer with waitrequest low.
  wire bus_req = (avs_read | avs_write) & ~wr_done_r;
  always @(posedge clk_sys) begin
    if (srst) begin
      port4_function_control_r <= `MMCS_RST_P4CTL;
      memory_control_r <= `MMCS_RST_MEMCTL;
      address_control_r <= `MMCS_RST_ADDRESS_CONTROL;
      stack_ptr_ext_r <= 2'h0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      wr_done_r <= 1'b0;
    end else begin
      wr_done_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      if (bus_req && avs_waitrequest) begin
        // First cycle of a request: answer on the next edge.
        avs_waitrequest <= 1'b0;
        wr_done_r <= 1'b1;
        avs_readdata <= 32'h0000_0000;
        if (avs_write) begin
          case (avs_address)
            `MMCS_ADDR_P4CTL: port4_function_control_r <= avs_writedata[7:0];
            `MMCS_ADDR_MEMCTL: memory_control_r <= avs_writedata[7:0];
            `MMCS_ADDR_ADDRESS_CONTROL: address_control_r <= avs_writedata[7:0];
            `MMCS_ADDR_STACK: stack_ptr_ext_r <= avs_writedata[1:0];
            default: ;
          endcase
        end else begin
          // Unmapped addresses read as zero.
          case (avs_address)
            `MMCS_ADDR_P4CTL: avs_readdata <= {24'h0, port4_function_control_r};
            `MMCS_ADDR_MEMCTL: avs_readdata <= {24'h0, memory_control_r};
            `MMCS_ADDR_ADDRESS_CONTROL: avs_readdata <= {24'h0, address_control_r};
            `MMCS_ADDR_STACK: avs_readdata <= {30'h0, stack_ptr_ext_r};
            `MMCS_ADDR_STAT: avs_readdata <= {27'h0, access_count_r, shared_mode,
                                              wide_stack_en};
            default: avs_readdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Address decode.
  // Stack accesses form a 10-bit address in the lowest 1kB of SRAM.
  wire [9:0] stack_addr = {stack_ptr_ext_r, stack_ptr};
  // Data window hit for the current map code.
  reg sram_data_hit;
  always @* begin
    case ({internal_map_sel_hi, internal_map_sel_lo})
      2'h0: sram_data_hit = (acc_addr[22:12] == `MMCS_SRAM_HI_BASE);
      2'h1: sram_data_hit = (acc_addr[22:12] == `MMCS_SRAM_LO_BASE);
      2'h2: sram_data_hit = (acc_addr[22:12] == `MMCS_SRAM_UP_BASE);
      default: sram_data_hit = 1'b0;
    endcase
  end
  wire shared_hit = shared_mode && (acc_addr[22:12] == `MMCS_SRAM_UP_BASE);
  // Program fetches hit SRAM only in shared mode, so a loader runs off-bus.
  wire code_hit = acc_code & shared_hit;
  wire data_hit = ~acc_code & (sram_data_hit | shared_hit);
  // The lowest 1kB belongs to the stack when the wide stack is on.
  wire stack_zone = wide_stack_en && (acc_addr[11:10] == `MMCS_STACK_TOP);
  wire stack_hit = acc_stack & wide_stack_en;
  wire sram_hit = code_hit | stack_hit | (data_hit & ~stack_zone);
  wire can_hit = ~acc_code & ~acc_stack &
    (can_area_sel ? (acc_addr[22:9] == `MMCS_CAN_UP_BASE)
                  : (acc_addr[22:9] == `MMCS_CAN_LO_BASE));
  wire int_hit = sram_hit | can_hit;
  // Upper address lines width by code.
  reg [3:0] upper_mask;
  always @* begin
    case (upper_code)
      3'h4: upper_mask = 4'h1;
      3'h5: upper_mask = 4'h3;
      3'h6: upper_mask = 4'h7;
      3'h7: upper_mask = 4'hF;
      default: upper_mask = 4'h0;
    endcase
  end
  reg [3:0] ce_mask;
  always @* begin
    case (ce_code)
      3'h4: ce_mask = 4'h1;
      3'h5: ce_mask = 4'h3;
      3'h6: ce_mask = 4'h7;
      3'h7: ce_mask = 4'hF;
      default: ce_mask = 4'h0;
    endcase
  end
  // Block decode, one instance per chip enable.
  wire [3:0] blk_raw;
  // Addresses above the external space never select a chip.
  wire [3:0] blk_hit = blk_raw & {4{~acc_addr[22]}};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ce
      mmcs_ce_decode #(.IDX(gi[1:0])) u_dec (
        .addr(acc_addr[21:0]),
        .upper_code(upper_code),
        .ce_code(ce_code),
        .hit(blk_raw[gi])
      );
    end
  endgenerate
  // Data chip enables follow the same blocks for external data accesses.
  // Combined blocks route data accesses onto the program enable.
  wire data_combined = ~acc_code & |(blk_hit & combined_chip_sel);
  wire [3:0] prog_ce = acc_code ? blk_hit : (blk_hit & combined_chip_sel);
  wire [3:0] data_ce = acc_code ? 4'h0 : (blk_hit & ~combined_chip_sel);
  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer: two cycles internal, three-phase external cycle.
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_INT = 2'h1;
  localparam [1:0] ST_ADDR = 2'h2;
  localparam [1:0] ST_STRB = 2'h3;
  reg [1:0] state_r;
  reg [1:0] cnt_r;
  reg comb_r;
  always @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ST_IDLE;
      cnt_r <= 2'h0;
      comb_r <= 1'b0;
      acc_done <= 1'b0;
      acc_internal <= 1'b0;
      acc_can <= 1'b0;
      sram_addr <= 12'h000;
      can_addr <= 9'h000;
      access_count_r <= 3'h0;
      port4_out <= 8'h00;
      port4_oe <= 8'h00;
      port5_hi_out <= 4'hF;
      port2_out <= 8'h00;
      port1_out <= 8'h00;
      port1_oe <= 1'b0;
      port0_out <= 8'h00;
      port0_oe <= 1'b0;
      ale <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      program_read_strobe_n <= 1'b1;
    end else begin
      acc_done <= 1'b0;
      // Pins configured as I/O are released by this block.
      port4_oe <= {upper_mask, ce_mask};
      case (state_r)
        ST_IDLE: begin
          // A request still high in the done cycle is the old one; skip it.
          if (acc_req && !acc_done && int_hit) begin
            // Internal hit: no strobes, fixed two cycles.
            state_r <= ST_INT;
            cnt_r <= `MMCS_INT_CYCLES - 2'h1;
            acc_internal <= 1'b1;
            acc_can <= can_hit;
            sram_addr <= stack_hit ? {2'h0, stack_addr} : acc_addr[11:0];
            can_addr <= acc_addr[8:0];
          end else if (acc_req && !acc_done) begin
            // External access: drive address, enables and ALE.
            state_r <= ST_ADDR;
            acc_internal <= 1'b0;
            acc_can <= 1'b0;
            comb_r <= data_combined;
            port4_out <= {acc_addr[19:16] & upper_mask, ~prog_ce & ce_mask};
            port5_hi_out <= ~data_ce;
            port2_out <= acc_addr[15:8];
            port0_out <= acc_addr[7:0];
            port0_oe <= ~demux_mode;
            port1_out <= acc_addr[7:0];
            port1_oe <= demux_mode;
            ale <= 1'b1;
          end
        end
        ST_INT: begin
          if (cnt_r == 2'h1) begin
            acc_done <= 1'b1;
            access_count_r <= access_count_r + 3'h1;
            state_r <= ST_IDLE;
          end
          cnt_r <= cnt_r - 2'h1;
        end
        ST_ADDR: begin
          ale <= 1'b0;
          state_r <= ST_STRB;
          if (acc_wr) begin
            port0_out <= acc_wdata;
            port0_oe <= 1'b1;
            write_strobe_n <= 1'b0;
          end else begin
            port0_oe <= 1'b0;
            if (acc_code || comb_r) begin
              program_read_strobe_n <= 1'b0;
            end else begin
              read_strobe_n <= 1'b0;
            end
          end
        end
        ST_STRB: begin
          // Release strobes and enables, complete the access.
          write_strobe_n <= 1'b1;
          read_strobe_n <= 1'b1;
          program_read_strobe_n <= 1'b1;
          port0_oe <= 1'b0;
          port4_out[3:0] <= ce_mask;
          port5_hi_out <= 4'hF;
          acc_done <= 1'b1;
          access_count_r <= access_count_r + 3'h1;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// *** mmcs_monitor.sv ***
// Port checker for the memory-map decoder.
`timescale 1ns/1ps
module mmcs_monitor (
  input wire clk_sys,
  input wire srst,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire acc_req,
  input wire acc_done,
  input wire acc_internal,
  input wire acc_can,
  input wire ale,
  input wire write_strobe_n,
  input wire read_strobe_n,
  input wire program_read_strobe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_int_quiet;
    acc_internal || acc_can |-> write_strobe_n && read_strobe_n && program_read_strobe_n;
  endproperty
  a_int_quiet: assert property (p_int_quiet) else $error("strobe on internal hit");
  property p_int_noale;
    acc_internal || acc_can |-> !ale;
  endproperty
  a_int_noale: assert property (p_int_noale) else $error("bus cycle on internal hit");
  property p_done_lat;
    $rose(acc_req) |-> ##[2:3] acc_done;
  endproperty
  a_done_lat: assert property (p_done_lat) else $error("access length wrong");
  property p_done_pulse;
    acc_done |=> !acc_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_ale_one;
    ale |=> !ale;
  endproperty
  a_ale_one: assert property (p_ale_one) else $error("address latch too long");
  property p_rd_after_ale;
    $fell(read_strobe_n) || $fell(program_read_strobe_n) |-> $past(ale);
  endproperty
  a_rd_after_ale: assert property (p_rd_after_ale) else $error("read without address");
  property p_excl;
    !(!read_strobe_n && !program_read_strobe_n) && !(!write_strobe_n && !program_read_strobe_n);
  endproperty
  a_excl: assert property (p_excl) else $error("two strobes at once");
  property p_wait1;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait1: assert property (p_wait1) else $error("bus answer late");
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("answer longer than one cycle");
  c_int: cover property (acc_done && acc_internal);
  c_can: cover property (acc_done && acc_can);
  c_prd: cover property ($fell(program_read_strobe_n));
  c_wr: cover property ($fell(write_strobe_n));
endmodule
bind mmcs_top mmcs_monitor mon (.clk_sys(clk_sys), .srst(srst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .acc_req(acc_req),
  .acc_done(acc_done), .acc_internal(acc_internal), .acc_can(acc_can), .ale(ale),
  .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
  .program_read_strobe_n(program_read_strobe_n));

// *** mmcs_ext_mem.sv ***
// External memory model that latches the address and counts strobes.
`timescale 1ns/1ps
module mmcs_ext_mem (
  input wire clk_sys,
  input wire [7:0] port4_out,
  input wire [7:0] port2_out,
  input wire [7:0] port1_out,
  input wire port1_oe,
  input wire [7:0] port0_out,
  input wire ale,
  input wire write_strobe_n,
  input wire read_strobe_n,
  input wire program_read_strobe_n,
  output reg [19:0] lat_addr = 20'h00000,
  output reg [7:0] rd_cnt = 8'h00,
  output reg [7:0] prd_cnt = 8'h00,
  output reg [7:0] wr_cnt = 8'h00,
  output reg [7:0] wr_data = 8'h00
);
  reg [2:0] prev_r = 3'h7; // Last strobe levels, so each pulse counts once.
  // Latch the address at the latch pulse and take write data under the strobe.
  always @(posedge clk_sys) begin
    prev_r <= {read_strobe_n, program_read_strobe_n, write_strobe_n};
    if (ale) begin
      lat_addr <= {port4_out[7:4], port2_out, port1_oe ? port1_out : port0_out};
    end
    if (prev_r[2] && !read_strobe_n) begin
      rd_cnt <= rd_cnt + 8'h01;
    end
    if (prev_r[1] && !program_read_strobe_n) begin
      prd_cnt <= prd_cnt + 8'h01;
    end
    if (prev_r[0] && !write_strobe_n) begin
      wr_cnt <= wr_cnt + 8'h01;
      wr_data <= port0_out;
    end
  end
endmodule

// *** testbench.sv ***
// Self-checking bench for the memory-map decoder.
`timescale 1ns/1ps
`include "mmcs_consts.vh"
module testbench;
  logic clk_sys = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic acc_req = 1'b0, acc_code = 1'b0, acc_stack = 1'b0, acc_wr = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0, rv;
  logic [22:0] acc_addr = 23'h0;
  logic [7:0] acc_wdata = 8'h00, stack_ptr = 8'h00, n_rd, n_prd, n_wr;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, acc_done, acc_internal, acc_can, port1_oe, port0_oe, ale;
  wire write_strobe_n, read_strobe_n, program_read_strobe_n;
  wire [11:0] sram_addr;
  wire [8:0] can_addr;
  wire [7:0] port4_out, port4_oe, port2_out, port1_out, port0_out;
  wire [7:0] rd_cnt, prd_cnt, wr_cnt, wr_data;
  wire [3:0] port5_hi_out;
  wire [19:0] lat_addr;
  logic si, sc;
  logic [11:0] sa;
  logic [8:0] sca;
  logic [3:0] ce;
  int err_count = 0, samples_checked = 0;
  logic [2:0] ucode [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [3:0] pmask [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
  int shf [5] = '{15, 17, 18, 19, 20};
  logic [10:0] base [4] = '{11'h00F, 11'h000, 11'h400, 11'h400};
  always #5 clk_sys = ~clk_sys;
  mmcs_top dut (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .acc_req(acc_req),
    .acc_code(acc_code), .acc_stack(acc_stack), .acc_wr(acc_wr), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .stack_ptr(stack_ptr), .acc_done(acc_done),
    .acc_internal(acc_internal), .acc_can(acc_can), .sram_addr(sram_addr),
    .can_addr(can_addr), .port4_out(port4_out), .port4_oe(port4_oe),
    .port5_hi_out(port5_hi_out), .port2_out(port2_out), .port1_out(port1_out),
    .port1_oe(port1_oe), .port0_out(port0_out), .port0_oe(port0_oe), .ale(ale),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .program_read_strobe_n(program_read_strobe_n));
  mmcs_ext_mem ext (.clk_sys(clk_sys), .port4_out(port4_out), .port2_out(port2_out),
    .port1_out(port1_out), .port1_oe(port1_oe), .port0_out(port0_out), .ale(ale),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .program_read_strobe_n(program_read_strobe_n), .lat_addr(lat_addr),
    .rd_cnt(rd_cnt), .prd_cnt(prd_cnt), .wr_cnt(wr_cnt), .wr_data(wr_data));
  // Compare one value against its expectation and count the result.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One register cycle, held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  // One core access; enables are taken while ALE is high, internal outputs in the done cycle.
  task automatic acc(input logic c, input logic w, input logic [22:0] a);
    acc_code <= c;
    acc_wr <= w;
    acc_addr <= a;
    acc_wdata <= 8'hA5;
    acc_req <= 1'b1;
    n_rd = rd_cnt;
    n_prd = prd_cnt;
    n_wr = wr_cnt;
    ce = 4'hF;
    // Enables stand while the address latch pulse is high.
    do begin
      @(posedge clk_sys);
      if (ale === 1'b1) ce = port4_out[3:0] | ~port4_oe[3:0];
    end while (acc_done !== 1'b1);
    {si, sc, sa, sca} = {acc_internal, acc_can, sram_addr, can_addr};
    acc_req <= 1'b0;
    acc_stack <= 1'b0;
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(port4_oe, 8'hFF);
    bus(0, `MMCS_ADDR_P4CTL, 8'h00);
    chk(rv, 32'h3F);
    bus(1, 10'h3F0, 8'h5A);
    bus(0, 10'h3F0, 8'h00);
    chk(rv, 32'h0);
    acc(1, 0, 22'h0);
    chk(ce, 4'hE);
    for (int i = 0; i < 5; i++) begin
      bus(1, `MMCS_ADDR_P4CTL, {2'b00, ucode[i], ucode[i]});
      acc(1, 0, 22'h1 << shf[i]);
      chk(ce, i > 1 ? 4'hD : 4'hF);
      acc(1, 0, (22'h4 << shf[i]) - 22'h1);
      chk(ce, i == 4 ? 4'h7 : 4'hF);
      chk(port4_oe, {pmask[i], pmask[i]});
    end
    for (int m = 0; m < 4; m++) begin
      bus(1, `MMCS_ADDR_MEMCTL, {m[1:0], 6'h00});
      acc(0, 0, {base[m], 12'h123});
      chk({si, sa, rd_cnt}, {1'b1, 12'h123, n_rd});
      acc(0, 0, 22'h00F456);
      chk({si, rd_cnt}, m == 0 ? {1'b1, n_rd} : {1'b0, n_rd + 8'h01});
    end
    acc(1, 0, 23'h400200);
    chk({si, prd_cnt}, {1'b1, n_prd});
    bus(1, `MMCS_ADDR_ADDRESS_CONTROL, 8'h04);
    bus(0, `MMCS_ADDR_STAT, 8'h00);
    chk(rv[1:0], 2'h2);
    bus(1, `MMCS_ADDR_MEMCTL, 8'h00);
    bus(0, `MMCS_ADDR_STAT, 8'h00);
    chk(rv[1:0], 2'h1);
    acc(0, 0, 22'h00F010);
    chk(si, 1'b0);
    bus(1, `MMCS_ADDR_STACK, 8'h01);
    stack_ptr <= 8'h23;
    acc_stack <= 1'b1;
    acc(0, 0, 22'h0);
    chk({si, sa}, {1'b1, 12'h123});
    bus(1, `MMCS_ADDR_ADDRESS_CONTROL, 8'h00);
    acc(0, 0, 22'h00EE10);
    chk({sc, sca}, {1'b1, 9'h010});
    bus(1, `MMCS_ADDR_MEMCTL, 8'h20);
    acc(0, 0, 23'h401010);
    chk({sc, sca}, {1'b1, 9'h010});
    acc(0, 0, 22'h00EE10);
    chk(sc, 1'b0);
    bus(1, `MMCS_ADDR_MEMCTL, 8'h01);
    acc(0, 0, 22'h000100);
    chk({ce, prd_cnt, rd_cnt}, {4'hE, n_prd + 8'h01, n_rd});
    acc(0, 1, 22'h000100);
    chk({wr_cnt, wr_data}, {n_wr + 8'h01, 8'hA5});
    bus(1, `MMCS_ADDR_MEMCTL, 8'h00);
    acc(0, 0, 22'h000177);
    chk({ce, rd_cnt, lat_addr}, {4'hF, n_rd + 8'h01, 20'h00177});
    bus(1, `MMCS_ADDR_ADDRESS_CONTROL, 8'h01);
    acc(0, 0, 22'h000155);
    chk(lat_addr, 20'h00155);
    close_out;
  end
  initial begin
    #200000;
    err_count++;
    close_out;
  end
endmodule
